//--- common/trh_regs.svh
// register offsets, field positions, reset values and timing counts of the handshake block
`ifndef TRH_REGS_SVH
`define TRH_REGS_SVH
`define TRH_ADDR_CTRL      12'h000
`define TRH_ADDR_LAT       12'h004
`define TRH_ADDR_WORDS     12'h008
`define TRH_ADDR_STATUS    12'h00C
`define TRH_ADDR_ISTAT     12'h010
`define TRH_ADDR_IMASK     12'h014
`define TRH_ADDR_RDBK      12'h018
`define TRH_CTRL_ANALOG    0
`define TRH_CTRL_CONT      1
`define TRH_CTRL_ERRCHK    2
`define TRH_CTRL_ANAPORT   3
`define TRH_EV_OCAL        0
`define TRH_EV_WR          1
`define TRH_EV_RD          2
`define TRH_EV_ERR         3
`define TRH_CTRL_RST       4'hC
`define TRH_LAT_RST        8'h02
`define TRH_WORDS_RST      8'h08
`define TRH_NUM_CH         4'hF
`define TRH_OCAL_PER_CH    8'h0F
`define TRH_ANA_LAST       8'h03
`define TRH_RD_LAST        8'h03
`endif

//--- common/trh_pkg.sv
// types shared by the reconfiguration handshake block
package trh_pkg;
	typedef enum logic [2:0] {
		TRH_ST_RST   = 3'h0,
		TRH_ST_OCAL  = 3'h1,
		TRH_ST_IDLE  = 3'h3,
		TRH_ST_FETCH = 3'h2,
		TRH_ST_XWR   = 3'h6,
		TRH_ST_ANA   = 3'h7,
		TRH_ST_RD    = 3'h5
	} trh_state_e;
endpackage

//--- core/trh_top.sv
// reconfiguration controller fabric handshake with apb control registers
`timescale 1ns/1ns
`default_nettype none
`include "trh_regs.svh"

module trh_top import trh_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        write_strobe,
	input  wire logic        read_strobe,
	input  wire logic [7:0]  wr_value,
	output logic             busy,
	output logic             error,
	output logic             readback_valid,
	output logic      [7:0]  readback_data,
	output logic      [7:0]  cfg_addr,
	input  wire logic [15:0] cfg_data,
	output logic             xcvr_wr,
	output logic      [15:0] xcvr_data,
	output logic             irq
);

	// ==========================================================
	// declarations
	trh_state_e  state_ff;
	logic [7:0]  cnt_ff;
	logic [3:0]  ch_ff;
	logic [7:0]  idx_ff;
	logic [7:0]  ana_set_ff;
	logic [7:0]  ana_pend_ff;
	logic        busy_ff;
	logic        error_ff;
	logic        rdvalid_ff;
	logic [7:0]  rdbk_ff;
	logic [7:0]  cfg_addr_ff;
	logic        xcvr_wr_ff;
	logic [15:0] xcvr_data_ff;
	logic        irq_ff;
	logic [3:0]  ctrl_ff;
	logic [7:0]  lat_ff;
	logic [7:0]  words_ff;
	logic [3:0]  istat_ff;
	logic [3:0]  imask_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        bad_op;
	logic        err_hit;
	logic        abortable;
	logic        abort;
	logic        go_wr;
	logic        go_rd;
	logic        ocal_last;
	logic        last_word;
	logic [3:0]  ev;
	logic        apb_acc;
	logic        apb_done;
	logic [31:0] rd_mux;
	logic        addr_hit;
	logic [3:0]  istat_clr;
	logic        c_analog;
	logic        c_cont;
	logic        c_errchk;
	logic        c_anaport;

	assign c_analog  = ctrl_ff[`TRH_CTRL_ANALOG];
	assign c_cont    = ctrl_ff[`TRH_CTRL_CONT];
	assign c_errchk  = ctrl_ff[`TRH_CTRL_ERRCHK];
	assign c_anaport = ctrl_ff[`TRH_CTRL_ANAPORT];

	// ==========================================================
	// operation checking
	// strobes are single-cycle, so each high cycle counts as one request
	always_comb begin
		bad_op = 1'b0;
		if (read_strobe && !(c_analog && c_anaport)) begin
			bad_op = 1'b1;
		end
		if ((write_strobe || read_strobe) && (state_ff != TRH_ST_IDLE)) begin
			bad_op = 1'b1;
		end
		if (write_strobe && read_strobe) begin
			bad_op = 1'b1;
		end
		if (write_strobe && !c_analog && (words_ff == 8'h00)) begin
			bad_op = 1'b1;
		end
	end

	assign err_hit   = bad_op && c_errchk;
	// calibration is never cut short; only transactions abort
	assign abortable = (state_ff == TRH_ST_FETCH) || (state_ff == TRH_ST_XWR) ||
		(state_ff == TRH_ST_ANA) || (state_ff == TRH_ST_RD);
	assign abort     = err_hit && abortable;
	assign go_wr     = write_strobe && (state_ff == TRH_ST_IDLE) && !bad_op;
	assign go_rd     = read_strobe && (state_ff == TRH_ST_IDLE) && !bad_op;
	assign ocal_last = (cnt_ff == `TRH_OCAL_PER_CH) && (ch_ff == `TRH_NUM_CH);
	assign last_word = (idx_ff == words_ff - 8'h01);

	// event pulses feeding the sticky status
	always_comb begin
		ev = 4'h0;
		ev[`TRH_EV_OCAL] = (state_ff == TRH_ST_OCAL) && ocal_last;
		ev[`TRH_EV_WR]   = !abort && (((state_ff == TRH_ST_XWR) && !(c_cont && !last_word)) ||
			((state_ff == TRH_ST_ANA) && (cnt_ff == `TRH_ANA_LAST)));
		ev[`TRH_EV_RD]   = !abort && (state_ff == TRH_ST_RD) && (cnt_ff == `TRH_RD_LAST);
		ev[`TRH_EV_ERR]  = err_hit;
	end

	// ==========================================================
	// sequencer: calibration, file writes, analog accesses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff     <= TRH_ST_RST;
			cnt_ff       <= 8'h00;
			ch_ff        <= 4'h0;
			idx_ff       <= 8'h00;
			ana_set_ff   <= 8'h00;
			ana_pend_ff  <= 8'h00;
			busy_ff      <= 1'b0;
			rdvalid_ff   <= 1'b0;
			rdbk_ff      <= 8'h00;
			cfg_addr_ff  <= 8'h00;
			xcvr_wr_ff   <= 1'b0;
			xcvr_data_ff <= 16'h0000;
		end else begin
			rdvalid_ff <= 1'b0;
			xcvr_wr_ff <= 1'b0;
			if (abort) begin
				state_ff <= TRH_ST_IDLE;
				busy_ff  <= 1'b0;
			end else begin
				case (state_ff)
					TRH_ST_RST: begin
						state_ff <= TRH_ST_OCAL;
						busy_ff  <= 1'b1;
					end
					TRH_ST_OCAL: begin
						// sixteen slots of cancellation per receiver channel
						cnt_ff <= cnt_ff + 8'h01;
						if (cnt_ff == `TRH_OCAL_PER_CH) begin
							cnt_ff <= 8'h00;
							ch_ff  <= ch_ff + 4'h1;
						end
						if (ocal_last) begin
							state_ff <= TRH_ST_IDLE;
							busy_ff  <= 1'b0;
						end
					end
					TRH_ST_IDLE: begin
						cnt_ff <= 8'h00;
						if (go_wr && c_analog) begin
							ana_pend_ff <= wr_value;
							state_ff    <= TRH_ST_ANA;
							busy_ff     <= 1'b1;
						end else if (go_wr) begin
							// continuous mode always restarts at the first word
							cfg_addr_ff <= c_cont ? 8'h00 : idx_ff;
							idx_ff      <= c_cont ? 8'h00 : idx_ff;
							state_ff    <= TRH_ST_FETCH;
							busy_ff     <= 1'b1;
						end else if (go_rd) begin
							state_ff <= TRH_ST_RD;
							busy_ff  <= 1'b1;
						end
					end
					TRH_ST_FETCH: begin
						// regular mode uses a single cycle of fetch latency
						if (!c_cont || (cnt_ff == lat_ff)) begin
							xcvr_data_ff <= cfg_data;
							xcvr_wr_ff   <= 1'b1;
							state_ff     <= TRH_ST_XWR;
						end else begin
							cnt_ff <= cnt_ff + 8'h01;
						end
					end
					TRH_ST_XWR: begin
						idx_ff <= last_word ? 8'h00 : idx_ff + 8'h01;
						cnt_ff <= 8'h00;
						if (c_cont && !last_word) begin
							cfg_addr_ff <= idx_ff + 8'h01;
							state_ff    <= TRH_ST_FETCH;
						end else begin
							state_ff <= TRH_ST_IDLE;
							busy_ff  <= 1'b0;
						end
					end
					TRH_ST_ANA: begin
						cnt_ff <= cnt_ff + 8'h01;
						if (cnt_ff == `TRH_ANA_LAST) begin
							ana_set_ff <= ana_pend_ff;
							state_ff   <= TRH_ST_IDLE;
							busy_ff    <= 1'b0;
						end
					end
					TRH_ST_RD: begin
						cnt_ff <= cnt_ff + 8'h01;
						if (cnt_ff == `TRH_RD_LAST) begin
							rdbk_ff    <= ana_set_ff;
							rdvalid_ff <= 1'b1;
							state_ff   <= TRH_ST_IDLE;
							busy_ff    <= 1'b0;
						end
					end
					default: begin
						state_ff <= TRH_ST_IDLE;
						busy_ff  <= 1'b0;
					end
				endcase
			end
		end
	end

	// error level: set wins over the clear by a new accepted transaction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_ff <= 1'b0;
		end else if (err_hit) begin
			error_ff <= 1'b1;
		end else if (go_wr || go_rd) begin
			error_ff <= 1'b0;
		end
	end

	// ==========================================================
	// apb slave: one wait state, every access answered
	assign apb_acc  = psel && penable;
	assign apb_done = apb_acc && pready_ff;

	always_comb begin
		rd_mux   = 32'h0000_0000;
		addr_hit = 1'b1;
		if (paddr == `TRH_ADDR_CTRL) begin
			rd_mux[3:0] = ctrl_ff;
		end else if (paddr == `TRH_ADDR_LAT) begin
			rd_mux[7:0] = lat_ff;
		end else if (paddr == `TRH_ADDR_WORDS) begin
			rd_mux[7:0] = words_ff;
		end else if (paddr == `TRH_ADDR_STATUS) begin
			rd_mux[15:0] = {idx_ff, 1'b0, state_ff, 2'b00, error_ff, busy_ff};
		end else if (paddr == `TRH_ADDR_ISTAT) begin
			rd_mux[3:0] = istat_ff;
		end else if (paddr == `TRH_ADDR_IMASK) begin
			rd_mux[3:0] = imask_ff;
		end else if (paddr == `TRH_ADDR_RDBK) begin
			rd_mux[7:0] = ana_set_ff;
		end else begin
			addr_hit = 1'b0;
		end
	end

	// answer phase registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= apb_acc && !pready_ff;
			pslverr_ff <= apb_acc && !pready_ff && !addr_hit;
			if (apb_acc && !pready_ff && !pwrite) begin
				prdata_ff <= rd_mux;
			end
		end
	end

	// software-written configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff  <= `TRH_CTRL_RST;
			lat_ff   <= `TRH_LAT_RST;
			words_ff <= `TRH_WORDS_RST;
			imask_ff <= 4'h0;
		end else if (apb_done && pwrite) begin
			if (paddr == `TRH_ADDR_CTRL) begin
				ctrl_ff <= pwdata[3:0];
			end else if (paddr == `TRH_ADDR_LAT) begin
				lat_ff <= pwdata[7:0];
			end else if (paddr == `TRH_ADDR_WORDS) begin
				words_ff <= pwdata[7:0];
			end else if (paddr == `TRH_ADDR_IMASK) begin
				imask_ff <= pwdata[3:0];
			end
		end
	end

	// sticky events, cleared by reading; a same-cycle event survives
	assign istat_clr = (apb_done && !pwrite && (paddr == `TRH_ADDR_ISTAT)) ? 4'hF : 4'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_ff <= 4'h0;
			irq_ff   <= 1'b0;
		end else begin
			istat_ff <= (istat_ff & ~istat_clr) | ev;
			irq_ff   <= |(istat_ff & imask_ff);
		end
	end

	// ==========================================================
	// outputs
	assign prdata         = prdata_ff;
	assign pready         = pready_ff;
	assign pslverr        = pslverr_ff;
	assign busy           = busy_ff;
	assign error          = error_ff;
	assign readback_valid = rdvalid_ff;
	assign readback_data  = rdbk_ff;
	assign cfg_addr       = cfg_addr_ff;
	assign xcvr_wr        = xcvr_wr_ff;
	assign xcvr_data      = xcvr_data_ff;
	assign irq            = irq_ff;

	// ==========================================================
	// assertions
	default clocking trh_cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence rd_clean_s;
		go_rd ##1 (!err_hit) [*4];
	endsequence

	busy_first_a: assert property ((state_ff == TRH_ST_RST) |-> !busy_ff ##1 busy_ff)
		else $error("busy not low then high after reset");
	ocal_busy_a: assert property ((state_ff == TRH_ST_OCAL) |-> busy_ff)
		else $error("busy low during offset cancellation");
	ocal_done_a: assert property (ev[`TRH_EV_OCAL] |=> !busy_ff && (state_ff == TRH_ST_IDLE))
		else $error("busy did not fall after offset cancellation");
	ana_busy_a: assert property (go_wr && c_analog |=> busy_ff)
		else $error("busy low during analog write");
	chan_busy_a: assert property ((state_ff == TRH_ST_FETCH) || (state_ff == TRH_ST_XWR) |-> busy_ff)
		else $error("busy low while writing file words");
	cont_next_a: assert property ((state_ff == TRH_ST_XWR) && c_cont && !last_word && !abort
		|=> (state_ff == TRH_ST_FETCH))
		else $error("continuous write stopped early");
	fetch_lat_a: assert property ($rose(xcvr_wr_ff) && c_cont |-> $past(cnt_ff) == $past(lat_ff))
		else $error("fetch latency not honoured");
	reg_one_a: assert property ((state_ff == TRH_ST_XWR) && !c_cont && !abort
		|=> (state_ff == TRH_ST_IDLE) && !busy_ff)
		else $error("regular write wrote more than one word");
	rd_mode_a: assert property (read_strobe && (state_ff == TRH_ST_IDLE) && !(c_analog && c_anaport)
		|=> (state_ff == TRH_ST_IDLE))
		else $error("read accepted outside analog mode");
	rd_valid_a: assert property (rd_clean_s |=> readback_valid && (readback_data == ana_set_ff))
		else $error("readback valid missing after read");
	valid_src_a: assert property (readback_valid |-> $past(state_ff) == TRH_ST_RD)
		else $error("readback valid without read");
	err_flag_a: assert property (err_hit |=> error_ff)
		else $error("error not flagged");
	err_busy_a: assert property (abort |=> !busy_ff && (state_ff == TRH_ST_IDLE))
		else $error("busy not dropped on unsupported operation");

endmodule
`default_nettype wire

//--- bench/trh_fabric.sv
// fabric-side user logic model: strobes, config file words, result tally
`timescale 1ns/1ns
`default_nettype none
module trh_fabric (
	input  wire logic        pclk,
	input  wire logic        busy,
	input  wire logic        readback_valid,
	input  wire logic [7:0]  readback_data,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic        xcvr_wr,
	input  wire logic [15:0] xcvr_data,
	output logic             write_strobe,
	output logic             read_strobe,
	output logic      [7:0]  wr_value,
	output logic      [15:0] cfg_data
);
	int          n_busy;
	int          n_wr;
	int          n_rb;
	logic [15:0] last_wr;
	logic [7:0]  last_rb;
	// word pattern carries its index, so a misordered fetch shows up
	assign cfg_data = {8'hA5, cfg_addr};
	initial begin
		write_strobe = 1'b0;
		read_strobe  = 1'b0;
		wr_value     = 8'h00;
	end
	// one tally per clock; readback is taken only while flagged valid
	always @(posedge pclk) begin
		if (busy === 1'b1)
			n_busy++;
		if (xcvr_wr === 1'b1) begin
			n_wr++;
			last_wr = xcvr_data;
		end
		if (readback_valid === 1'b1) begin
			n_rb++;
			last_rb = readback_data;
		end
	end
	task automatic clr();
		n_busy = 0;
		n_wr   = 0;
		n_rb   = 0;
	endtask
	// one-cycle strobe; a longer one would ask for a second transaction
	task automatic pulse(input logic w, input logic r, input logic [7:0] v);
		@(posedge pclk);
		write_strobe <= w;
		read_strobe  <= r;
		wr_value     <= v;
		@(posedge pclk);
		write_strobe <= 1'b0;
		read_strobe  <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// self-checking testbench of the reconfiguration handshake block
`timescale 1ns/1ns
`default_nettype none
`include "trh_regs.svh"
module tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        write_strobe;
	logic        read_strobe;
	logic [7:0]  wr_value;
	logic        busy;
	logic        error;
	logic        readback_valid;
	logic [7:0]  readback_data;
	logic [7:0]  cfg_addr;
	logic [15:0] cfg_data;
	logic        xcvr_wr;
	logic [15:0] xcvr_data;
	logic        irq;
	int          failures;
	int          samples_checked;
	trh_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.wr_value(wr_value), .busy(busy), .error(error), .readback_valid(readback_valid),
		.readback_data(readback_data), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
		.xcvr_wr(xcvr_wr), .xcvr_data(xcvr_data), .irq(irq));
	trh_fabric fab (.pclk(pclk), .busy(busy), .readback_valid(readback_valid),
		.readback_data(readback_data), .cfg_addr(cfg_addr), .xcvr_wr(xcvr_wr),
		.xcvr_data(xcvr_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.wr_value(wr_value), .cfg_data(cfg_data));
	// 50 MHz clock
	always #10 pclk = ~pclk;
	// ==========================================================
	// compare, closing and timeout tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic limit(input int n, input int lim);
		if (n >= lim) begin
			failures++;
			$display("CHECK FAILED t=%0t wait ran out", $time);
			end_of_test();
		end
	endtask
	// ==========================================================
	// apb master: request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		limit(n, 50);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
		chk_bit(e, xe);
	endtask
	// waits until the controller reports idle, at most 2000 clocks
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (busy !== 1'b0 && n < 2000);
		limit(n, 2000);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		failures = 0;
		samples_checked = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		fab.clr();
		#1 chk_bit(busy, 1'b0);
		repeat (2) @(posedge pclk);
		#1 chk_bit(busy, 1'b1);
		rd(`TRH_ADDR_CTRL, 32'hC, 1'b0);
		rd(`TRH_ADDR_LAT, 32'h2, 1'b0);
		rd(`TRH_ADDR_WORDS, 32'h8, 1'b0);
		rd(`TRH_ADDR_IMASK, 32'h0, 1'b0);
		rd(12'h01C, 32'h0, 1'b1);
		// a strobe during calibration is refused but must not cut it short
		fab.pulse(1'b1, 1'b0, 8'h00);
		#1 chk_bit(error, 1'b1);
		chk_bit(busy, 1'b1);
		wait_idle();
		chk(fab.n_busy, 32'd256);
		chk_bit(irq, 1'b0);
		wr(`TRH_ADDR_IMASK, 32'h9);
		repeat (3) @(posedge pclk);
		#1 chk_bit(irq, 1'b1);
		rd(`TRH_ADDR_ISTAT, 32'h9, 1'b0);
		rd(`TRH_ADDR_ISTAT, 32'h0, 1'b0);
		repeat (3) @(posedge pclk);
		#1 chk_bit(irq, 1'b0);
		// regular channel writes: one strobe per file word
		wr(`TRH_ADDR_CTRL, 32'h4);
		for (int i = 0; i < 3; i++) begin
			fab.clr();
			fab.pulse(1'b1, 1'b0, 8'h00);
			wait_idle();
			chk_bit(error, 1'b0);
			chk(fab.n_wr, 32'd1);
			chk({16'h0, fab.last_wr}, {16'h0, 8'hA5, 8'(i)});
			chk(fab.n_busy, 32'd2);
		end
		// idle state code and the advanced word index show in the status word
		rd(`TRH_ADDR_STATUS, 32'h330, 1'b0);
		// continuous write: one strobe, whole file, latency per fetch
		wr(`TRH_ADDR_WORDS, 32'h3);
		wr(`TRH_ADDR_LAT, 32'h4);
		wr(`TRH_ADDR_CTRL, 32'h6);
		fab.clr();
		fab.pulse(1'b1, 1'b0, 8'h00);
		wait_idle();
		chk(fab.n_wr, 32'd3);
		chk({16'h0, fab.last_wr}, 32'h0000A502);
		chk(fab.n_busy, 32'd18);
		// a strobe during the first word's fetch aborts the run before any word is written
		fab.clr();
		fab.pulse(1'b1, 1'b0, 8'h00);
		fab.pulse(1'b1, 1'b0, 8'h00);
		#1 chk_bit(busy, 1'b0);
		chk_bit(error, 1'b1);
		chk(fab.n_wr, 32'd0);
		rd(`TRH_ADDR_STATUS, 32'h32, 1'b0);
		rd(`TRH_ADDR_ISTAT, 32'hA, 1'b0);
		// read outside analog mode is unsupported; an accepted write clears error first
		wr(`TRH_ADDR_CTRL, 32'h4);
		fab.pulse(1'b1, 1'b0, 8'h00);
		wait_idle();
		chk_bit(error, 1'b0);
		fab.pulse(1'b0, 1'b1, 8'h00);
		#1 chk_bit(error, 1'b1);
		chk_bit(busy, 1'b0);
		rd(`TRH_ADDR_ISTAT, 32'hA, 1'b0);
		// analog write then read back through the fabric port
		wr(`TRH_ADDR_CTRL, 32'hD);
		fab.clr();
		fab.pulse(1'b1, 1'b0, 8'h5A);
		wait_idle();
		chk(fab.n_busy, 32'd4);
		rd(`TRH_ADDR_RDBK, 32'h5A, 1'b0);
		fab.clr();
		fab.pulse(1'b0, 1'b1, 8'h00);
		wait_idle();
		repeat (2) @(posedge pclk);
		chk(fab.n_busy, 32'd4);
		chk(fab.n_rb, 32'd1);
		chk({24'h0, fab.last_rb}, 32'h5A);
		// with checking off an unsupported read is dropped silently
		wr(`TRH_ADDR_CTRL, 32'h1);
		fab.pulse(1'b0, 1'b1, 8'h00);
		#1 chk_bit(error, 1'b0);
		chk_bit(busy, 1'b0);
		// analog mode without analog ports has no read
		wr(`TRH_ADDR_CTRL, 32'h5);
		fab.pulse(1'b0, 1'b1, 8'h00);
		#1 chk_bit(error, 1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
